// ==== pacc_top.sv ====
// pulse accumulator with periodic interrupt timer and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "pacc_defines.svh"
module pacc_top
#(
    parameter int DIV_WIDTH = 16
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic pulse_input_pin,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irqRequest,
    output logic captureFourEnable,
    output logic compareFiveEnable
);
    typedef struct packed
    {
        logic [7:0] control;
        logic [7:0] countValue;
        logic [2:0] flags;
        logic [2:0] masks;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        pacc_pkg::pacc_wr_e wrState;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic irq;
        logic cap4;
        logic cmp5;
    } pacc_top_s;
    pacc_top_s state_reg;
    pacc_top_s state_next;

    logic [DIV_WIDTH-1:0] divCount;
    logic selEdge;
    logic gateActive;
    logic gateTick;
    logic periodicTick;
    logic countStep;
    logic edgeEvent;
    logic ovfEvent;
    logic periodicEvent;
    logic wrFire;
    logic [7:0] ctl;

    // flag bits packed into their register positions
    function automatic pacc_pkg::pacc_byte_t packFlags(input logic [2:0] f);
        pacc_pkg::pacc_byte_t b;
        b = '0;
        b[`PACC_FLG_PERIODIC] = f[2];
        b[`PACC_FLG_OVERFLOW] = f[1];
        b[`PACC_FLG_EDGE] = f[0];
        return b;
    endfunction : packFlags

    // tick as the low n divider bits reach all ones: one clock short of a full period after reset, never at it
    function automatic logic tapTick(input logic [DIV_WIDTH-1:0] c, input int n);
        logic t;
        t = 1'b1;
        for (int i = 0; i < DIV_WIDTH; i++)
        begin
            if (i < n && !c[i])
            begin
                t = 1'b0;
            end
        end
        return t;
    endfunction : tapTick

    pacc_divider #(.WIDTH(DIV_WIDTH)) uDivider
    (
        .clock(clock),
        .reset(reset),
        .count(divCount)
    );

    pacc_edge_detect uEdge
    (
        .clock(clock),
        .reset(reset),
        .pulseIn(pulse_input_pin),
        .edgePolarity(state_reg.control[`PACC_CTL_EDGE]),
        .selEdge(selEdge),
        .gateActive(gateActive)
    );

    assign ctl = state_reg.control;
    // one free-running chain serves both taps; no prescaler sits in front
    assign gateTick = tapTick(divCount, `PACC_GATE_DIV_LOG2);
    // the divider never restarts on flag clear, so periods run back to back
    assign periodicTick = tapTick(divCount,
        `PACC_PERIODIC_LOG2 + int'(ctl[`PACC_CTL_RATE_HI:`PACC_CTL_RATE_LO]));

    // counting source chosen by mode, blocked while disabled
    always_comb
    begin
        countStep = 1'b0;
        if (ctl[`PACC_CTL_ENABLE])
        begin
            if (!ctl[`PACC_CTL_MODE])
            begin
                countStep = selEdge;
            end
            else
            begin
                countStep = gateTick & gateActive;
            end
        end
    end
    // in gated mode the selected edge is the gate falling inactive
    assign edgeEvent = ctl[`PACC_CTL_ENABLE] & selEdge;
    assign ovfEvent = countStep & (state_reg.countValue == `PACC_COUNT_MAX);
    assign periodicEvent = periodicTick;
    assign wrFire = state_reg.awHeld & state_reg.wHeld &
        (state_reg.wrState == pacc_pkg::PACC_WR_IDLE);

    // register file, counter and bus slave in one next-state process
    always_comb
    begin
        logic [7:0] wb;
        logic [2:0] clr;
        wb = state_reg.wData[7:0];
        clr = '0;
        state_next = state_reg;
        // counting happens in one clock edge, so reads see a whole value
        if (countStep)
        begin
            state_next.countValue = state_reg.countValue + 8'h01;
        end
        // write channels taken independently, either order
        if (!state_reg.awHeld && s_axi_awvalid)
        begin
            state_next.awHeld = 1'b1;
            state_next.awAddr = s_axi_awaddr;
        end
        if (!state_reg.wHeld && s_axi_wvalid)
        begin
            state_next.wHeld = 1'b1;
            state_next.wData = s_axi_wdata;
            state_next.wStrb = s_axi_wstrb;
        end
        case (state_reg.wrState)
            pacc_pkg::PACC_WR_IDLE:
            begin
                if (wrFire)
                begin
                    state_next.bResp = `PACC_RESP_OKAY;
                    if (state_reg.wStrb[0])
                    begin
                        if (state_reg.awAddr == `PACC_ADDR_CONTROL)
                        begin
                            state_next.control = wb & `PACC_CTL_WMASK;
                        end
                        else if (state_reg.awAddr == `PACC_ADDR_COUNT)
                        begin
                            // software write wins over a same-cycle increment
                            state_next.countValue = wb;
                        end
                        else if (state_reg.awAddr == `PACC_ADDR_FLAGS)
                        begin
                            clr = {wb[`PACC_FLG_PERIODIC], wb[`PACC_FLG_OVERFLOW],
                                wb[`PACC_FLG_EDGE]};
                        end
                        else if (state_reg.awAddr == `PACC_ADDR_MASKS)
                        begin
                            state_next.masks = {wb[`PACC_FLG_PERIODIC],
                                wb[`PACC_FLG_OVERFLOW], wb[`PACC_FLG_EDGE]};
                        end
                        else
                        begin
                            state_next.bResp = `PACC_RESP_SLVERR;
                        end
                    end
                    else if (state_reg.awAddr != `PACC_ADDR_CONTROL &&
                        state_reg.awAddr != `PACC_ADDR_COUNT &&
                        state_reg.awAddr != `PACC_ADDR_FLAGS &&
                        state_reg.awAddr != `PACC_ADDR_MASKS)
                    begin
                        state_next.bResp = `PACC_RESP_SLVERR;
                    end
                    state_next.wrState = pacc_pkg::PACC_WR_RESP;
                end
            end
            pacc_pkg::PACC_WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    state_next.wrState = pacc_pkg::PACC_WR_IDLE;
                    state_next.awHeld = 1'b0;
                    state_next.wHeld = 1'b0;
                end
            end
            default:
            begin
                state_next.wrState = pacc_pkg::PACC_WR_IDLE;
            end
        endcase
        // set beats clear for every flag
        state_next.flags = (state_reg.flags & ~clr) |
            {periodicEvent, ovfEvent, edgeEvent};
        // read channel: count is always readable, gate state irrelevant
        if (state_reg.rValid)
        begin
            if (s_axi_rready)
            begin
                state_next.rValid = 1'b0;
            end
        end
        else if (s_axi_arvalid)
        begin
            state_next.rValid = 1'b1;
            state_next.rResp = `PACC_RESP_OKAY;
            state_next.rData = '0;
            if (s_axi_araddr == `PACC_ADDR_CONTROL)
            begin
                state_next.rData[7:0] = state_reg.control;
            end
            else if (s_axi_araddr == `PACC_ADDR_COUNT)
            begin
                state_next.rData[7:0] = state_reg.countValue;
            end
            else if (s_axi_araddr == `PACC_ADDR_FLAGS)
            begin
                state_next.rData[7:0] = packFlags(state_reg.flags);
            end
            else if (s_axi_araddr == `PACC_ADDR_MASKS)
            begin
                state_next.rData[7:0] = packFlags(state_reg.masks);
            end
            else
            begin
                state_next.rResp = `PACC_RESP_SLVERR;
            end
        end
        // enables gate the level request, never the flags themselves
        state_next.irq = |(state_next.flags & state_next.masks);
        state_next.cap4 = state_next.control[`PACC_CTL_CAPSEL];
        state_next.cmp5 = ~state_next.control[`PACC_CTL_CAPSEL];
    end

    // count value keeps its contents through reset
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.countValue <= state_reg.countValue;
            state_reg.cmp5 <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready = ~state_reg.awHeld;
    assign s_axi_wready = ~state_reg.wHeld;
    assign s_axi_bvalid = (state_reg.wrState == pacc_pkg::PACC_WR_RESP);
    assign s_axi_bresp = state_reg.bResp;
    assign s_axi_arready = ~state_reg.rValid;
    assign s_axi_rvalid = state_reg.rValid;
    assign s_axi_rdata = state_reg.rData;
    assign s_axi_rresp = state_reg.rResp;
    assign irqRequest = state_reg.irq;
    assign captureFourEnable = state_reg.cap4;
    assign compareFiveEnable = state_reg.cmp5;

    // overflow flag follows a rollover within one edge
    AST_OVF_SET: assert property (@(posedge clock) disable iff (reset)
        ovfEvent |=> state_reg.flags[1]) else $error("overflow flag not set");
    AST_EDGE_SET: assert property (@(posedge clock) disable iff (reset)
        edgeEvent |=> state_reg.flags[0]) else $error("edge flag not set");
    AST_DISABLED_HOLD: assert property (@(posedge clock) disable iff (reset)
        !ctl[`PACC_CTL_ENABLE] && !wrFire |=> $stable(state_reg.countValue))
        else $error("counter moved while disabled");
    AST_EVENT_COUNT: assert property (@(posedge clock) disable iff (reset)
        countStep && !wrFire |=> state_reg.countValue == $past(state_reg.countValue) + 8'h01)
        else $error("counter missed a step");
    AST_GATE_INHIBIT: assert property (@(posedge clock) disable iff (reset)
        ctl[`PACC_CTL_MODE] && !gateActive |-> !countStep)
        else $error("count while gate inhibited");
    AST_SEL_EXCLUSIVE: assert property (@(posedge clock) disable iff (reset)
        captureFourEnable != compareFiveEnable) else $error("capture and compare both");
    AST_IRQ_MASK: assert property (@(posedge clock) disable iff (reset)
        state_reg.flags[1] && state_reg.masks[1] |-> irqRequest)
        else $error("overflow irq missing");
    sequence periodicFire;
        periodicEvent ##1 state_reg.flags[2];
    endsequence
    AST_PERIODIC_FLAG: assert property (@(posedge clock) disable iff (reset)
        periodicEvent |-> periodicFire) else $error("periodic flag not set");
    AST_GATE_RATE: assert property (@(posedge clock) disable iff (reset)
        gateTick |=> !gateTick [*8]) else $error("gate tick too fast");
endmodule : pacc_top
`default_nettype wire

// ==== pacc_defines.svh ====
// constants for the pulse accumulator and periodic interrupt block
`ifndef PACC_DEFINES_SVH
`define PACC_DEFINES_SVH
// register byte addresses
`define PACC_ADDR_CONTROL 8'h00
`define PACC_ADDR_COUNT 8'h04
`define PACC_ADDR_FLAGS 8'h08
`define PACC_ADDR_MASKS 8'h0C
// control register fields
`define PACC_CTL_ENABLE 6
`define PACC_CTL_MODE 5
`define PACC_CTL_EDGE 4
`define PACC_CTL_CAPSEL 2
`define PACC_CTL_RATE_HI 1
`define PACC_CTL_RATE_LO 0
`define PACC_CTL_WMASK 8'h77
// flag and mask register fields
`define PACC_FLG_PERIODIC 6
`define PACC_FLG_OVERFLOW 5
`define PACC_FLG_EDGE 4
`define PACC_FLG_WMASK 8'h70
// bus responses
`define PACC_RESP_OKAY 2'h0
`define PACC_RESP_SLVERR 2'h2
// timing
`define PACC_GATE_DIV_LOG2 6
`define PACC_PERIODIC_LOG2 13
`define PACC_COUNT_MAX 8'hFF
`endif

// ==== pacc_pkg.sv ====
// shared types for the pulse accumulator block
package pacc_pkg;
    typedef logic [7:0] pacc_byte_t;
    typedef enum logic [1:0]
    {
        PACC_WR_IDLE = 2'b00,
        PACC_WR_RESP = 2'b01
    } pacc_wr_e;
endpackage : pacc_pkg

// ==== pacc_edge_detect.sv ====
// edge detector and gate qualifier on the pulse input
`timescale 1ns/1ps
`default_nettype none
`include "pacc_defines.svh"
module pacc_edge_detect
(
    input wire logic clock,
    input wire logic reset,
    input wire logic pulseIn,
    input wire logic edgePolarity,
    output logic selEdge,
    output logic gateActive
);
    typedef struct packed
    {
        logic last;
    } pacc_ed_s;
    pacc_ed_s state_reg;
    pacc_ed_s state_next;

    // remember last level
    always_comb
    begin
        state_next = state_reg;
        state_next.last = pulseIn;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_reg.last <= pulseIn; // idle level, so no false edge follows reset
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // polarity 0: falling edge, 1: rising edge; gate active opposite of inhibit level
    assign selEdge = edgePolarity ? (pulseIn & ~state_reg.last) : (~pulseIn & state_reg.last);
    assign gateActive = edgePolarity ? ~pulseIn : pulseIn;
endmodule : pacc_edge_detect
`default_nettype wire

// ==== pacc_divider.sv ====
// free-running power-of-two divider; its taps are decoded into ticks in pacc_top
`timescale 1ns/1ps
`default_nettype none
`include "pacc_defines.svh"
module pacc_divider
#(
    parameter int WIDTH = 16
)
(
    input wire logic clock,
    input wire logic reset,
    output logic [WIDTH-1:0] count
);
    typedef struct packed
    {
        logic [WIDTH-1:0] cnt;
    } pacc_div_s;
    pacc_div_s state_reg;
    pacc_div_s state_next;

    // runs on every clock, only reset stops it
    always_comb
    begin
        state_next = state_reg;
        state_next.cnt = state_reg.cnt + 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign count = state_reg.cnt;
endmodule : pacc_divider
`default_nettype wire

// ==== pacc_pulse_src.sv ====
// behavioural pulse source standing in for the device driving the pulse input pin
`timescale 1ns/1ps
`default_nettype none
module pacc_pulse_src
#(
    parameter int HOLD = 3
)
(
    input wire logic clock,
    input wire logic go,
    input wire logic [7:0] toggles,
    output logic pinLevel,
    output logic busy
);
    initial
    begin
        pinLevel = 1'b0;
        busy = 1'b0;
    end
    // each level held HOLD clocks: never faster than half the clock rate
    always
    begin
        @(posedge clock);
        if (go)
        begin
            busy <= 1'b1;
            repeat (toggles)
            begin
                repeat (HOLD) @(posedge clock);
                pinLevel <= ~pinLevel;
            end
            repeat (HOLD) @(posedge clock);
            busy <= 1'b0;
        end
    end
endmodule : pacc_pulse_src
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the pulse accumulator block
`timescale 1ns/1ps
`default_nettype none
`include "pacc_defines.svh"
module tb_top;
    localparam logic [1:0] OK = `PACC_RESP_OKAY;
    localparam logic [7:0] A_CTL = `PACC_ADDR_CONTROL;
    localparam logic [7:0] A_CNT = `PACC_ADDR_COUNT;
    localparam logic [7:0] A_FLG = `PACC_ADDR_FLAGS;
    localparam logic [7:0] A_MSK = `PACC_ADDR_MASKS;
    logic clock, reset, go, pin, busy, irq, capFour, cmpFive, expLevel;
    logic [7:0] awaddr, araddr, toggles;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    int errors, numChecks, cyc, expCount, p, n, e, t0, t1;

    pacc_pulse_src u_src (.clock(clock), .go(go), .toggles(toggles), .pinLevel(pin),
        .busy(busy));
    pacc_top u_dut (.clock(clock), .reset(reset), .pulse_input_pin(pin),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irqRequest(irq),
        .captureFourEnable(capFour), .compareFiveEnable(cmpFive));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // cycles since reset release, the reference for periodic timing
    always @(posedge clock) cyc <= reset ? 0 : cyc + 1;

    task automatic close_out;
        $display("checks %0d mismatches %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_up;
        errors++;
        $display("wrong value at %0t: wait ran out", $time);
        close_out();
    endtask : give_up

    // bready and rready stay high, so each answer is taken at the edge it shows
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int k;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (k == 50) give_up();
        check({30'h0, bresp}, {30'h0, er});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int k;
        araddr <= a;
        arvalid <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (k == 50) give_up();
        d = rdata;
        check({30'h0, rresp}, {30'h0, er});
    endtask : axi_rd

    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] d;
        axi_rd(a, OK, d);
        check(d & m, x);
    endtask : chk

    // rising edges among n toggles from level lvl, or falling ones
    function automatic int edges(int cnt, logic lvl, logic pol);
        return (lvl == pol) ? cnt / 2 : (cnt + 1) / 2;
    endfunction : edges

    task automatic pulse(input int cnt);
        int k;
        toggles <= cnt[7:0];
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clock);
        if (k == 3000) give_up();
        expLevel ^= cnt[0];
        repeat (4) @(posedge clock); // lets the last edge reach the counter
    endtask : pulse

    task automatic wait_irq(output int t);
        int k;
        repeat (3) @(posedge clock);
        for (k = 0; k < 70000 && irq !== 1'b1; k++) @(posedge clock);
        if (k == 70000) give_up();
        t = cyc;
    endtask : wait_irq

    task automatic do_reset;
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
    endtask : do_reset

    initial
    begin
        {reset, go, awvalid, wvalid, arvalid} = 5'h10;
        {bready, rready} = 2'h3;
        wstrb = 4'hF;
        {awaddr, araddr, toggles, wdata} = '0;
        {errors, numChecks, cyc, expLevel} = '0;
        void'($urandom(32'hD765C990));
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        // reset values, and an unmapped place
        chk(A_CTL, 32'hFFFFFFFF, 32'h0);
        chk(A_FLG, 32'hFFFFFFFF, 32'h0);
        chk(A_MSK, 32'hFFFFFFFF, 32'h0);
        check({30'h0, capFour, cmpFive}, 32'h1);
        axi_rd(8'h10, `PACC_RESP_SLVERR, rd);
        check(rd, 32'h0);
        axi_wr(8'h10, 8'h5A, `PACC_RESP_SLVERR);
        $display("test reset_values done");
        // event counting, both polarities, random start and pulse count
        for (p = 0; p < 2; p++)
        begin
            n = 9 + $urandom % 6;
            expCount = $urandom % 256;
            e = edges(n, expLevel, p[0]);
            axi_wr(A_CNT, expCount[7:0], OK);
            axi_wr(A_FLG, 8'h70, OK);
            axi_wr(A_CTL, {3'b010, p[0], 4'h0}, OK);
            pulse(n);
            chk(A_FLG, 32'h30, (expCount + e > 255) ? 32'h30 : 32'h10);
            expCount = (expCount + e) % 256;
            chk(A_CNT, 32'hFFFFFFFF, expCount);
        end
        $display("test event_count done");
        // disabled: no count, no edge or overflow flag
        axi_wr(A_FLG, 8'h70, OK);
        axi_wr(A_CTL, 8'h00, OK);
        pulse(6);
        chk(A_CNT, 32'hFFFFFFFF, expCount);
        chk(A_FLG, 32'h30, 32'h0);
        // lane zero off: the write is answered but changes nothing
        wstrb <= 4'h0;
        axi_wr(A_CNT, 8'h5A, OK);
        wstrb <= 4'hF;
        chk(A_CNT, 32'hFFFFFFFF, expCount);
        // request follows flag and enable, enable leaves the flag alone
        axi_wr(A_CNT, 8'h00, OK);
        axi_wr(A_MSK, 8'h30, OK);
        axi_wr(A_CTL, 8'h40, OK);
        pulse(2);
        check({31'h0, irq}, 32'h1);
        axi_wr(A_FLG, 8'h70, OK);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        axi_wr(A_MSK, 8'h00, OK);
        pulse(2);
        chk(A_FLG, 32'h30, 32'h10);
        check({31'h0, irq}, 32'h0);
        chk(A_CNT, 32'hFFFFFFFF, 32'h2);
        // overflow alone raises the request when only its enable is set
        axi_wr(A_CNT, 8'hFF, OK);
        axi_wr(A_MSK, 8'h20, OK);
        pulse(2);
        check({31'h0, irq}, 32'h1);
        chk(A_FLG, 32'h30, 32'h30);
        axi_wr(A_FLG, 8'h20, OK);
        chk(A_FLG, 32'h30, 32'h10);
        check({31'h0, irq}, 32'h0);
        $display("test enable_and_request done");
        // gated accumulation, both polarities
        for (p = 0; p < 2; p++)
        begin
            axi_wr(A_CTL, 8'h00, OK);
            if (expLevel != p[0]) pulse(1);
            axi_wr(A_CNT, 8'h00, OK);
            axi_wr(A_FLG, 8'h70, OK);
            axi_wr(A_CTL, {3'b011, p[0], 4'h0}, OK);
            repeat (640) @(posedge clock);
            chk(A_CNT, 32'hFFFFFFFF, 32'h0);
            pulse(1);
            chk(A_FLG, 32'h30, 32'h0);
            repeat (640) @(posedge clock);
            pulse(1);
            chk(A_FLG, 32'h30, 32'h10);
            axi_rd(A_CNT, OK, rd);
            check({31'h0, rd > 9 && rd < 12}, 32'h1);
        end
        $display("test gated_count done");
        // capture and compare select, control write mask
        axi_wr(A_CTL, 8'hFF, OK);
        chk(A_CTL, 32'hFFFFFFFF, 32'h77);
        check({30'h0, capFour, cmpFive}, 32'h2);
        axi_wr(A_CTL, 8'h00, OK);
        repeat (2) @(posedge clock);
        check({30'h0, capFour, cmpFive}, 32'h1);
        $display("test select done");
        // count survives reset, then periodic timing for all rate codes
        n = $urandom % 256;
        axi_wr(A_CNT, n[7:0], OK);
        do_reset();
        chk(A_CNT, 32'hFFFFFFFF, n);
        axi_wr(A_MSK, 8'h40, OK);
        wait_irq(t0);
        repeat (100) @(posedge clock); // late clear must not shift the period
        axi_wr(A_FLG, 8'h70, OK);
        wait_irq(t1);
        check(t1 - t0, 8192);
        axi_wr(A_CTL, 8'h01, OK);
        axi_wr(A_FLG, 8'h70, OK);
        wait_irq(t1);
        check(t1 - t0, 32768 - 8192);
        do_reset();
        axi_wr(A_MSK, 8'h40, OK);
        axi_wr(A_CTL, 8'h02, OK);
        wait_irq(t1);
        check(t1 - t0, 32768 - 8192);
        axi_wr(A_CTL, 8'h03, OK);
        axi_wr(A_FLG, 8'h70, OK);
        wait_irq(t1);
        check(t1 - t0, 65536 - 8192);
        $display("test periodic done");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
